//--- design/brto_pkg.sv
/*
 * Constants and types of the boundary run-test operation logic.
 * Assumes a four-wire test port driven by an external port controller.
 */
package brto_pkg;

	// ******************************
	// Instruction register
	// ******************************
	localparam int BRTO_IR_W = 8;
	localparam logic [7:0] BRTO_IR_CAPTURE = 8'h81;
	localparam logic [7:0] BRTO_IR_RESET = 8'hFF;
	localparam logic [6:0] BRTO_OP_SAMPLE = 7'h02;
	localparam logic [6:0] BRTO_OP_EXTEST = 7'h03;
	localparam logic [6:0] BRTO_OP_RUN_TEST = 7'h09;
	localparam logic [6:0] BRTO_OP_CTRL_SCAN_NORMAL = 7'h0E;
	localparam logic [6:0] BRTO_OP_CTRL_SCAN_TEST = 7'h0F;

	// ******************************
	// Boundary chain layout
	// ******************************
	localparam int BRTO_CHAIN_W = 18;
	localparam int BRTO_IN_LSB = 0;
	localparam int BRTO_OUT_LSB = 8;
	localparam int BRTO_OE_LSB = 16;
	localparam int BRTO_CTRL_W = 2;
	localparam logic [1:0] BRTO_CTRL_RESET = 2'h0;
	localparam logic [1:0] BRTO_OE_RESET = 2'h3;
	localparam logic [15:0] BRTO_TAPS16 = 16'hB400;
	localparam logic [7:0] BRTO_TAPS8 = 8'hB8;

	typedef enum logic [1:0] {
		BRTO_MODE_SAMPLE_TOGGLE = 2'h0,
		BRTO_MODE_PATTERN = 2'h1,
		BRTO_MODE_SIGNATURE = 2'h2,
		BRTO_MODE_COMBINED = 2'h3
	} brto_mode_t;

	typedef enum logic [3:0] {
		BRTO_ST_TLR = 4'h0,
		BRTO_ST_RTI = 4'h1,
		BRTO_ST_SEL_DR = 4'h2,
		BRTO_ST_CAP_DR = 4'h3,
		BRTO_ST_SH_DR = 4'h4,
		BRTO_ST_EX1_DR = 4'h5,
		BRTO_ST_PA_DR = 4'h6,
		BRTO_ST_EX2_DR = 4'h7,
		BRTO_ST_UPD_DR = 4'h8,
		BRTO_ST_SEL_IR = 4'h9,
		BRTO_ST_CAP_IR = 4'hA,
		BRTO_ST_SH_IR = 4'hB,
		BRTO_ST_EX1_IR = 4'hC,
		BRTO_ST_PA_IR = 4'hD,
		BRTO_ST_EX2_IR = 4'hE,
		BRTO_ST_UPD_IR = 4'hF
	} brto_tap_state_t;

endpackage : brto_pkg

//--- design/brto_tap_if.sv
/*
 * Carries the port state from the state machine to the test logic.
 * Assumes both ends run on the test clock.
 */
`timescale 1ns/1ns
interface brto_tap_if import brto_pkg::*; ();
	brto_tap_state_t state;
	modport ctrl (output state);
	modport user (input state);
endinterface : brto_tap_if

//--- design/brto_lfsr_step.sv
/*
 * One step of a Fibonacci feedback register with optional parallel fold.
 * Assumes the caller holds the register and picks the taps.
 */
`timescale 1ns/1ns
module brto_lfsr_step import brto_pkg::*; #(
	parameter int W = 16,
	parameter logic [W-1:0] TAPS = BRTO_TAPS16
) (
	input wire logic [W-1:0] cur_i,
	input wire logic [W-1:0] data_i,
	input wire logic compress_i,
	output logic [W-1:0] nxt_o
);
	logic fb;

	assign fb = ^(cur_i & TAPS);
	assign nxt_o = {cur_i[W-2:0], fb} ^ (compress_i ? data_i : '0);
endmodule : brto_lfsr_step

//--- design/brto_tap_fsm.sv
/*
 * Test port state machine, advanced on the rising test clock edge.
 * Assumes mode select changes only on the falling edge.
 */
`timescale 1ns/1ns
module brto_tap_fsm import brto_pkg::*; (
	input wire logic tck_i,
	input wire logic rst_b_i,
	input wire logic tms_i,
	brto_tap_if.ctrl tap
);
	brto_tap_state_t state_ff;
	brto_tap_state_t nxt_state;

	always_comb begin
		unique case (state_ff)
			BRTO_ST_TLR: nxt_state = tms_i ? BRTO_ST_TLR : BRTO_ST_RTI;
			BRTO_ST_RTI: nxt_state = tms_i ? BRTO_ST_SEL_DR : BRTO_ST_RTI;
			BRTO_ST_SEL_DR: nxt_state = tms_i ? BRTO_ST_SEL_IR : BRTO_ST_CAP_DR;
			BRTO_ST_CAP_DR: nxt_state = tms_i ? BRTO_ST_EX1_DR : BRTO_ST_SH_DR;
			BRTO_ST_SH_DR: nxt_state = tms_i ? BRTO_ST_EX1_DR : BRTO_ST_SH_DR;
			BRTO_ST_EX1_DR: nxt_state = tms_i ? BRTO_ST_UPD_DR : BRTO_ST_PA_DR;
			BRTO_ST_PA_DR: nxt_state = tms_i ? BRTO_ST_EX2_DR : BRTO_ST_PA_DR;
			BRTO_ST_EX2_DR: nxt_state = tms_i ? BRTO_ST_UPD_DR : BRTO_ST_SH_DR;
			BRTO_ST_UPD_DR: nxt_state = tms_i ? BRTO_ST_SEL_DR : BRTO_ST_RTI;
			BRTO_ST_SEL_IR: nxt_state = tms_i ? BRTO_ST_TLR : BRTO_ST_CAP_IR;
			BRTO_ST_CAP_IR: nxt_state = tms_i ? BRTO_ST_EX1_IR : BRTO_ST_SH_IR;
			BRTO_ST_SH_IR: nxt_state = tms_i ? BRTO_ST_EX1_IR : BRTO_ST_SH_IR;
			BRTO_ST_EX1_IR: nxt_state = tms_i ? BRTO_ST_UPD_IR : BRTO_ST_PA_IR;
			BRTO_ST_PA_IR: nxt_state = tms_i ? BRTO_ST_EX2_IR : BRTO_ST_PA_IR;
			BRTO_ST_EX2_IR: nxt_state = tms_i ? BRTO_ST_UPD_IR : BRTO_ST_SH_IR;
			BRTO_ST_UPD_IR: nxt_state = tms_i ? BRTO_ST_SEL_DR : BRTO_ST_RTI;
		endcase
	end

	// ******************************
	// State register
	// ******************************
	always_ff @(posedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= BRTO_ST_TLR;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign tap.state = state_ff;
endmodule : brto_tap_fsm

//--- design/brto_run_test_ops.sv
/*
 * Boundary run-test operations of an octal buffer scan-test device:
 * instruction and control registers, boundary chain with shadow latches,
 * four self-test operations and a status crossing into the system clock.
 * Assumes an external port controller drives tck_i, tms_i and tdi_i,
 * changing them on the falling test clock edge.
 */
`timescale 1ns/1ns
module brto_run_test_ops import brto_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_b_o,
	input wire logic [7:0] pin_in_i,
	output logic [7:0] core_in_o,
	input wire logic [7:0] core_out_i,
	input wire logic [1:0] core_oe_b_i,
	output logic [7:0] pin_out_o,
	output logic [7:0] pin_out_oe_b_o,
	output logic test_mode_o,
	output logic run_active_o,
	output brto_mode_t op_mode_o
);
	// ******************************
	// Declarations
	// ******************************
	brto_tap_if tap ();

	logic [BRTO_IR_W-1:0] ir_shift_ff;
	logic [BRTO_IR_W-1:0] ir_ff;
	logic bypass_ff;
	logic [BRTO_CTRL_W-1:0] ctrl_shift_ff;
	logic [BRTO_CTRL_W-1:0] ctrl_ff;
	logic [BRTO_CHAIN_W-1:0] chain_ff;
	logic [7:0] in_shadow_ff;
	logic [7:0] out_shadow_ff;
	logic [1:0] oe_shadow_ff;
	logic tdo_ff;
	logic tdo_oe_b_ff;
	logic run_tck_ff;
	logic run_meta_ff;
	logic run_sync_ff;
	logic run_seen_ff;
	brto_mode_t op_mode_ff;

	logic run_instr;
	logic bsr_sel;
	logic ctrl_sel;
	logic test_mode;
	logic run_now;
	brto_mode_t mode;
	logic [15:0] nxt_lfsr16;
	logic [7:0] nxt_sig8;
	logic [7:0] nxt_prpg8;
	logic [BRTO_CHAIN_W-1:0] nxt_chain;
	logic serial_out;

	brto_tap_fsm u_tap_fsm (
		.tck_i(tck_i),
		.rst_b_i(rst_b_i),
		.tms_i(tms_i),
		.tap(tap)
	);

	// ******************************
	// Instruction decode
	// ******************************
	assign run_instr = (ir_ff[6:0] == BRTO_OP_RUN_TEST);
	assign bsr_sel = (ir_ff[6:0] == BRTO_OP_SAMPLE) ||
		(ir_ff[6:0] == BRTO_OP_EXTEST);
	assign ctrl_sel = (ir_ff[6:0] == BRTO_OP_CTRL_SCAN_NORMAL) ||
		(ir_ff[6:0] == BRTO_OP_CTRL_SCAN_TEST);
	assign test_mode = run_instr || (ir_ff[6:0] == BRTO_OP_EXTEST) ||
		(ir_ff[6:0] == BRTO_OP_CTRL_SCAN_TEST);
	assign mode = brto_mode_t'(ctrl_ff);
	assign run_now = (tap.state == BRTO_ST_RTI) && run_instr;

	// ******************************
	// Feedback steps
	// ******************************
	brto_lfsr_step #(.W(16), .TAPS(BRTO_TAPS16)) u_lfsr16 (
		.cur_i(chain_ff[BRTO_OUT_LSB+7:BRTO_IN_LSB]),
		.data_i({8'h00, pin_in_i}),
		.compress_i(mode == BRTO_MODE_SIGNATURE),
		.nxt_o(nxt_lfsr16)
	);

	brto_lfsr_step #(.W(8), .TAPS(BRTO_TAPS8)) u_sig8 (
		.cur_i(chain_ff[BRTO_IN_LSB+7:BRTO_IN_LSB]),
		.data_i(pin_in_i),
		.compress_i(1'h1),
		.nxt_o(nxt_sig8)
	);

	brto_lfsr_step #(.W(8), .TAPS(BRTO_TAPS8)) u_prpg8 (
		.cur_i(chain_ff[BRTO_OUT_LSB+7:BRTO_OUT_LSB]),
		.data_i(8'h00),
		.compress_i(1'h0),
		.nxt_o(nxt_prpg8)
	);

	// ******************************
	// Self-test step of the chain
	// ******************************
	always_comb begin
		nxt_chain = chain_ff;
		unique case (mode)
			BRTO_MODE_SAMPLE_TOGGLE: begin
				nxt_chain[BRTO_IN_LSB+:8] = pin_in_i;
				nxt_chain[BRTO_OUT_LSB+:8] = ~chain_ff[BRTO_OUT_LSB+:8];
			end
			BRTO_MODE_PATTERN: begin
				nxt_chain[15:0] = nxt_lfsr16;
			end
			BRTO_MODE_SIGNATURE: begin
				nxt_chain[15:0] = nxt_lfsr16;
			end
			BRTO_MODE_COMBINED: begin
				nxt_chain[BRTO_IN_LSB+:8] = nxt_sig8;
				nxt_chain[BRTO_OUT_LSB+:8] = nxt_prpg8;
			end
		endcase
	end

	// ******************************
	// Rising edge: shift stages
	// ******************************
	always_ff @(posedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ir_shift_ff <= '0;
		end else if (tap.state == BRTO_ST_CAP_IR) begin
			ir_shift_ff <= BRTO_IR_CAPTURE;
		end else if (tap.state == BRTO_ST_SH_IR) begin
			ir_shift_ff <= {tdi_i, ir_shift_ff[BRTO_IR_W-1:1]};
		end
	end

	always_ff @(posedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bypass_ff <= 1'h0;
		end else if (tap.state == BRTO_ST_CAP_DR) begin
			bypass_ff <= 1'h0;
		end else if (tap.state == BRTO_ST_SH_DR) begin
			bypass_ff <= tdi_i;
		end
	end

	always_ff @(posedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_shift_ff <= BRTO_CTRL_RESET;
		end else if (ctrl_sel && tap.state == BRTO_ST_CAP_DR) begin
			ctrl_shift_ff <= ctrl_ff;
		end else if (ctrl_sel && tap.state == BRTO_ST_SH_DR) begin
			ctrl_shift_ff <= {tdi_i, ctrl_shift_ff[BRTO_CTRL_W-1:1]};
		end
	end

	// Enable cells are only reached by scan, never by the self-test step
	always_ff @(posedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			chain_ff <= '0;
		end else if (bsr_sel && tap.state == BRTO_ST_CAP_DR) begin
			chain_ff[BRTO_IN_LSB+:8] <= pin_in_i;
			chain_ff[BRTO_OUT_LSB+:8] <= core_out_i;
		end else if (bsr_sel && tap.state == BRTO_ST_SH_DR) begin
			chain_ff <= {tdi_i, chain_ff[BRTO_CHAIN_W-1:1]};
		end else if (run_now) begin
			chain_ff <= nxt_chain;
		end
	end

	always_ff @(posedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_tck_ff <= 1'h0;
		end else begin
			run_tck_ff <= run_now;
		end
	end

	// ******************************
	// Falling edge: latches and pins
	// ******************************
	always_ff @(negedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ir_ff <= BRTO_IR_RESET;
		end else if (tap.state == BRTO_ST_TLR) begin
			ir_ff <= BRTO_IR_RESET;
		end else if (tap.state == BRTO_ST_UPD_IR) begin
			ir_ff <= ir_shift_ff;
		end
	end

	always_ff @(negedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_ff <= BRTO_CTRL_RESET;
		end else if (ctrl_sel && tap.state == BRTO_ST_UPD_DR) begin
			ctrl_ff <= ctrl_shift_ff;
		end
	end

	always_ff @(negedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			in_shadow_ff <= '0;
		end else if (run_now || (bsr_sel && tap.state == BRTO_ST_UPD_DR)) begin
			in_shadow_ff <= chain_ff[BRTO_IN_LSB+:8];
		end
	end

	always_ff @(negedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_shadow_ff <= '0;
		end else if ((run_now && mode != BRTO_MODE_SIGNATURE) ||
			(bsr_sel && tap.state == BRTO_ST_UPD_DR)) begin
			out_shadow_ff <= chain_ff[BRTO_OUT_LSB+:8];
		end
	end

	always_ff @(negedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oe_shadow_ff <= BRTO_OE_RESET;
		end else if (bsr_sel && tap.state == BRTO_ST_UPD_DR) begin
			oe_shadow_ff <= chain_ff[BRTO_OE_LSB+:2];
		end
	end

	always_comb begin
		serial_out = 1'h0;
		if (tap.state == BRTO_ST_SH_IR) begin
			serial_out = ir_shift_ff[0];
		end else if (bsr_sel) begin
			serial_out = chain_ff[0];
		end else if (ctrl_sel) begin
			serial_out = ctrl_shift_ff[0];
		end else begin
			serial_out = bypass_ff;
		end
	end

	always_ff @(negedge tck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tdo_ff <= 1'h0;
			tdo_oe_b_ff <= 1'h1;
		end else begin
			tdo_ff <= serial_out;
			tdo_oe_b_ff <= !(tap.state == BRTO_ST_SH_IR ||
				tap.state == BRTO_ST_SH_DR);
		end
	end

	assign tdo_o = tdo_ff;
	assign tdo_oe_b_o = tdo_oe_b_ff;
	assign test_mode_o = test_mode;
	assign core_in_o = test_mode ? in_shadow_ff : pin_in_i;
	assign pin_out_o = test_mode ? out_shadow_ff : core_out_i;
	assign pin_out_oe_b_o = test_mode ?
		{{4{oe_shadow_ff[1]}}, {4{oe_shadow_ff[0]}}} :
		{{4{core_oe_b_i[1]}}, {4{core_oe_b_i[0]}}};

	// ******************************
	// Status crossing to system clock
	// ******************************
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_meta_ff <= 1'h0;
			run_sync_ff <= 1'h0;
		end else begin
			run_meta_ff <= run_tck_ff;
			run_sync_ff <= run_meta_ff;
		end
	end

	// Control value only changes outside run-test idle, so it is settled
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_seen_ff <= 1'h0;
			op_mode_ff <= BRTO_MODE_SAMPLE_TOGGLE;
		end else begin
			run_seen_ff <= run_sync_ff;
			if (run_sync_ff && !run_seen_ff) begin
				op_mode_ff <= mode;
			end
		end
	end

	assign run_active_o = run_sync_ff;
	assign op_mode_o = op_mode_ff;

	// ******************************
	// Assertions
	// ******************************
	AST_IR_CAPTURE: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		tap.state == BRTO_ST_CAP_IR |=> ir_shift_ff == BRTO_IR_CAPTURE)
		else $error("instruction capture value wrong");

	AST_IR_SHIFT_IN: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		tap.state == BRTO_ST_SH_IR |=> ir_shift_ff[7] == $past(tdi_i))
		else $error("instruction shift lost serial bit");

	AST_IDLE_HOLDS: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		!run_now && !bsr_sel |=> $stable(chain_ff))
		else $error("chain moved outside run-test idle");

	AST_OE_EXCLUDED: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		run_now |=> $stable(chain_ff[17:16]))
		else $error("enable cells touched by self test");

	AST_SAMPLE_IN: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		run_now && mode == BRTO_MODE_SAMPLE_TOGGLE
		|=> chain_ff[7:0] == $past(pin_in_i))
		else $error("input pins not sampled");

	AST_TOGGLE_OUT: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		run_now && mode == BRTO_MODE_SAMPLE_TOGGLE
		|=> chain_ff[15:8] == ~$past(chain_ff[15:8]))
		else $error("output cells not toggled");

	AST_PATTERN16: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		run_now && mode == BRTO_MODE_PATTERN
		|=> chain_ff[15:0] == {$past(chain_ff[14:0]),
		^($past(chain_ff[15:0]) & BRTO_TAPS16)})
		else $error("16-bit pattern step wrong");

	AST_IN_SHADOW: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		run_now |-> in_shadow_ff == chain_ff[7:0])
		else $error("input latch not updated on fall");

	AST_SIG_HOLD: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		run_now && mode == BRTO_MODE_SIGNATURE |-> $stable(out_shadow_ff))
		else $error("output latch moved in signature mode");

	AST_PATTERN8: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		run_now && mode == BRTO_MODE_COMBINED
		|=> chain_ff[15:8] == {$past(chain_ff[14:8]),
		^($past(chain_ff[15:8]) & BRTO_TAPS8)})
		else $error("8-bit pattern step wrong");

	AST_TDO_DRIVEN: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		tap.state == BRTO_ST_SH_DR || tap.state == BRTO_ST_SH_IR
		|-> !tdo_oe_b_ff)
		else $error("serial out not driven while shifting");

	AST_WALK_TO_CAP: assert property (@(posedge tck_i) disable iff (!rst_b_i)
		tap.state == BRTO_ST_RTI && tms_i ##1 tms_i ##1 !tms_i
		|=> tap.state == BRTO_ST_CAP_IR)
		else $error("idle did not walk to capture-IR");

	COV_TOGGLE: cover property (@(posedge tck_i) disable iff (!rst_b_i)
		(run_now && mode == BRTO_MODE_SAMPLE_TOGGLE) [*3]);
	COV_PATTERN: cover property (@(posedge tck_i) disable iff (!rst_b_i)
		(run_now && mode == BRTO_MODE_PATTERN) [*3]);
	COV_SIGNATURE: cover property (@(posedge tck_i) disable iff (!rst_b_i)
		(run_now && mode == BRTO_MODE_SIGNATURE) [*3]);
	COV_COMBINED: cover property (@(posedge tck_i) disable iff (!rst_b_i)
		(run_now && mode == BRTO_MODE_COMBINED) [*3]);
endmodule : brto_run_test_ops

//--- bench/brto_tap_model.sv
/*
 * Port controller model: drives test clock, mode select and data in.
 * Assumes the device samples on rising and launches on falling edges.
 */
`timescale 1ns/1ns
module brto_tap_model (
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	input wire logic tdo_i,
	input wire logic tdo_oe_b_i
);
	logic oe_seen;

	initial begin
		tck_o = 1'h0;
		tms_o = 1'h1;
		tdi_o = 1'h0;
		oe_seen = 1'h0;
	end

	// ******************************
	// Test clock cycles
	// ******************************
	// Clock rests low between frames; data in toggles when not shifting
	task automatic step(input logic m, input logic d, input bit sh,
		output logic q);
		tms_o = m;
		tdi_o = sh ? d : ~tdi_o;
		#16 tck_o = 1'h1;
		q = tdo_i;
		if (sh)
			oe_seen = oe_seen | tdo_oe_b_i;
		#16 tck_o = 1'h0;
	endtask : step

	// Scan from idle back to idle, LSB first
	task automatic scan(input bit ir, input logic [17:0] din, input int n,
		output logic [17:0] dout);
		logic q;
		dout = '0;
		oe_seen = 1'h0;
		step(1'h1, 1'h0, 0, q);
		if (ir)
			step(1'h1, 1'h0, 0, q);
		step(1'h0, 1'h0, 0, q);
		step(1'h0, 1'h0, 0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], 1, q);
			dout[i] = q;
		end
		step(1'h1, 1'h0, 0, q);
		step(1'h0, 1'h0, 0, q);
	endtask : scan
endmodule : brto_tap_model

//--- bench/testbench.sv
/*
 * Self-checking bench of the boundary run-test operation logic.
 * Assumes the port controller model brto_tap_model on the test port.
 */
`timescale 1ns/1ns
module testbench import brto_pkg::*;;
	localparam logic [17:0] chain_seed = 18'h1B3C5;
	logic clk_i, rst_b_i, tck, tms, tdi, tdo, tdo_oe_b;
	logic [7:0] pin_in, core_in, core_out, pin_out, pin_oe_b;
	logic [1:0] core_oe_b;
	logic test_mode, run_active;
	brto_mode_t op_mode;
	int n_errors, n_tests;

	brto_run_test_ops DUT (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .tdo_o(tdo), .tdo_oe_b_o(tdo_oe_b),
		.pin_in_i(pin_in), .core_in_o(core_in), .core_out_i(core_out),
		.core_oe_b_i(core_oe_b), .pin_out_o(pin_out),
		.pin_out_oe_b_o(pin_oe_b), .test_mode_o(test_mode),
		.run_active_o(run_active), .op_mode_o(op_mode)
	);

	brto_tap_model partner (
		.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
		.tdo_oe_b_i(tdo_oe_b)
	);

	initial begin
		clk_i = 1'h0;
		forever #4 clk_i = ~clk_i;
	end

	// ******************************
	// Helpers
	// ******************************
	task automatic chk(input string what, input logic [17:0] exp,
		input logic [17:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	function automatic logic [15:0] f16(input logic [15:0] x);
		return {x[14:0], ^(x & BRTO_TAPS16)};
	endfunction : f16

	function automatic logic [7:0] f8(input logic [7:0] x);
		return {x[6:0], ^(x & BRTO_TAPS8)};
	endfunction : f8

	task automatic do_reset();
		logic q;
		@(posedge clk_i);
		rst_b_i <= 1'h0;
		partner.step(1'h1, 1'h0, 0, q);
		@(posedge clk_i);
		rst_b_i <= 1'h1;
		@(posedge clk_i);
		chk("tdo_oe_b reset", 1'h1, tdo_oe_b);
		chk("run_active reset", 1'h0, run_active);
		chk("op_mode reset", 2'h0, op_mode);
		chk("test_mode reset", 1'h0, test_mode);
		partner.step(1'h0, 1'h0, 0, q);
	endtask : do_reset

	// ******************************
	// Scenarios
	// ******************************
	task automatic t_capture();
		logic [17:0] d;
		do_reset();
		chk("pin_out normal", core_out, pin_out);
		chk("pin_oe_b normal", {{4{core_oe_b[1]}}, {4{core_oe_b[0]}}},
			pin_oe_b);
		chk("core_in normal", pin_in, core_in);
		partner.scan(1, 18'h000FF, 8, d);
		chk("ir capture", 8'h81, d[7:0]);
		chk("shift tdo_oe_b", 1'h0, partner.oe_seen);
		chk("idle tdo_oe_b", 1'h1, tdo_oe_b);
		partner.scan(0, 18'h00005, 3, d);
		chk("bypass shift", 3'h2, d[2:0]);
		partner.scan(1, 18'h00002, 8, d);
		partner.scan(0, 18'h00000, 18, d);
		chk("sample capture", {2'h0, core_out, pin_in}, d);
		chk("sample test_mode", 1'h0, test_mode);
		chk("sample pin_out", core_out, pin_out);
		partner.scan(1, 18'h0000F, 8, d);
		chk("ctrl scan test_mode", 1'h1, test_mode);
		chk("ctrl scan pin_oe_b", 8'h00, pin_oe_b);
		partner.scan(0, 18'h00003, 2, d);
		chk("ctrl capture", 2'h0, d[1:0]);
		partner.scan(0, 18'h00000, 2, d);
		chk("ctrl readback", 2'h3, d[1:0]);
	endtask : t_capture

	task automatic t_mode(input brto_mode_t m, input logic [7:0] pins);
		logic [17:0] d;
		logic [15:0] s;
		logic [7:0] eo;
		logic q;
		do_reset();
		partner.scan(1, 18'h0000E, 8, d);
		partner.scan(0, {16'h0000, m}, 2, d);
		partner.scan(1, 18'h00003, 8, d);
		partner.scan(0, chain_seed, 18, d);
		chk("extest pin_out", chain_seed[15:8], pin_out);
		@(posedge clk_i);
		pin_in <= pins;
		partner.scan(1, 18'h00009, 8, d);
		chk("run test_mode", 1'h1, test_mode);
		s = chain_seed[15:0];
		for (int k = 0; k < 5; k++) begin
			partner.step(1'h0, 1'h0, 0, q);
			case (m)
			BRTO_MODE_SAMPLE_TOGGLE: s = {~s[15:8], pins};
			BRTO_MODE_PATTERN: s = f16(s);
			BRTO_MODE_SIGNATURE: s = f16(s) ^ {8'h00, pins};
			default: s = {f8(s[15:8]), f8(s[7:0]) ^ pins};
			endcase
		end
		// Let the last falling-edge latch update settle before looking
		#1;
		eo = m == BRTO_MODE_SIGNATURE ? chain_seed[15:8] : s[15:8];
		chk("core_in run", s[7:0], core_in);
		chk("pin_out run", eo, pin_out);
		chk("pin_oe_b run", 8'h0F, pin_oe_b);
		repeat (4) @(posedge clk_i);
		chk("run_active", 1'h1, run_active);
		chk("op_mode", m, op_mode);
		partner.step(1'h1, 1'h0, 0, q);
		chk("pin_out after idle", eo, pin_out);
		repeat (5) partner.step(1'h1, 1'h0, 0, q);
		repeat (4) @(posedge clk_i);
		chk("run_active off", 1'h0, run_active);
	endtask : t_mode

	// ******************************
	// Sequence and verdict
	// ******************************
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	initial begin
		n_errors = 0;
		n_tests = 0;
		rst_b_i <= 1'h0;
		pin_in <= 8'hA5;
		core_out <= 8'h3C;
		core_oe_b <= 2'h2;
		repeat (4) @(posedge clk_i);
		t_capture();
		t_mode(BRTO_MODE_SAMPLE_TOGGLE, 8'h5A);
		t_mode(BRTO_MODE_PATTERN, 8'h96);
		t_mode(BRTO_MODE_SIGNATURE, 8'h69);
		t_mode(BRTO_MODE_COMBINED, 8'hE1);
		end_of_test();
	end

	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
endmodule : testbench
